// ==== sps_deg_conv.sv ====
`timescale 1ns/1ps
`default_nettype none
module sps_deg_conv (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // count in, degree out
  input wire logic [sps_pkg::POS_W-1:0] pos_i,
  output logic [sps_pkg::DEG_W-1:0] deg_o
);
  logic [sps_pkg::DEG_PROD_W-1:0] prod;
  logic [sps_pkg::DEG_W-1:0] deg_next;

  always_comb begin
    prod = sps_pkg::DEG_PROD_W'(pos_i) * sps_pkg::DEG_PROD_W'(sps_pkg::DEG_MUL);
    deg_next = sps_pkg::DEG_W'(prod >> sps_pkg::DEG_SHIFT);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deg_o <= '0;
    end else begin
      deg_o <= deg_next;
    end
  end
endmodule
`default_nettype wire

// ==== sps_motor_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sps_motor_model (
  // clock
  input wire logic clk_i,
  // drive from the block, manual steps, pace
  input wire logic drive_cw_i,
  input wire logic drive_ccw_i,
  input wire logic man_cw_i,
  input wire logic man_ccw_i,
  input wire logic slow_i,
  // sensor steps
  output logic sens_cw_o,
  output logic sens_ccw_o
);
  logic ph_reg = 1'b0;
  // slow pace passes drive steps only every other cycle; manual steps are not gated
  always_ff @(posedge clk_i) begin
    ph_reg <= ~ph_reg;
    sens_cw_o <= man_cw_i | (drive_cw_i & (ph_reg | ~slow_i));
    sens_ccw_o <= man_ccw_i | (drive_ccw_i & (ph_reg | ~slow_i));
  end
endmodule
`default_nettype wire

// ==== sps_pkg.sv ====
`default_nettype none
package sps_pkg;

  // ----------------------------------------------------------------
  // position scale
  // ----------------------------------------------------------------
  localparam int unsigned TEETH_PER_REV = 80;
  localparam int unsigned COUNTS_PER_TOOTH = 32768;
  localparam int unsigned REV_COUNTS = COUNTS_PER_TOOTH * TEETH_PER_REV;
  localparam int unsigned DEG_UNITS_PER_REV = 36000;
  localparam int unsigned POS_W = 22;
  localparam int unsigned DEG_W = 16;
  // 36000 / 2621440 reduces exactly to 225 / 2**14
  localparam int unsigned DEG_MUL = 225;
  localparam int unsigned DEG_SHIFT = 14;
  localparam int unsigned DEG_PROD_W = POS_W + 8;
  localparam logic [POS_W-1:0] POS_MAX = POS_W'(REV_COUNTS - 1);
  localparam logic [POS_W-1:0] POS_ZERO = '0;

  // ----------------------------------------------------------------
  // low-pass filter adjustment
  // ----------------------------------------------------------------
  localparam int unsigned CUT_W = 16;
  localparam logic [CUT_W-1:0] FIRST_PLUS_HZ = 16'h03E8;
  localparam logic [CUT_W-1:0] CUT_RESET_HZ = 16'h00C8;
  localparam logic [CUT_W-1:0] STEP_RESET = 16'h0001;
  localparam logic [CUT_W-1:0] STEP_MAX = 16'h2710;
  localparam logic [CUT_W-1:0] STEP_FACTOR = 16'h000A;
  localparam logic [CUT_W-1:0] CUT_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_POS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_POS_DEG = 8'h10;
  localparam logic [7:0] OFS_SOFT_PLUS = 8'h14;
  localparam logic [7:0] OFS_SOFT_MINUS = 8'h18;
  localparam logic [7:0] OFS_PRI_LP = 8'h1C;
  localparam logic [7:0] OFS_SEC_LP = 8'h20;
  localparam logic [7:0] OFS_ADJ_KEY = 8'h24;
  localparam logic [7:0] OFS_ADJ_STEP = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_FLIP_BIT = 0;
  localparam int unsigned ST_UNLOCKED_BIT = 0;
  localparam int unsigned ST_REFUSED_BIT = 1;
  localparam int unsigned ST_ADJ_BIT = 2;
  localparam int unsigned ST_SOFT_OT_BIT = 3;
  localparam int unsigned ST_ADJ_SEC_BIT = 4;
  localparam int unsigned KEY_START_PRI = 0;
  localparam int unsigned KEY_START_SEC = 1;
  localparam int unsigned KEY_PLUS = 2;
  localparam int unsigned KEY_MINUS = 3;
  localparam int unsigned KEY_SHIFT_PLUS = 4;
  localparam int unsigned KEY_STEP_REDUCE = 5;
  localparam int unsigned KEY_ENTER = 6;
  localparam int unsigned KEY_BACKSPACE = 7;

  // arbitrary unlock key value
  localparam logic [31:0] UNLOCK_KEY = 32'h5A5A_1234;

  typedef enum logic [0:0] {
    SPS_ADJ_IDLE = 1'b0,
    SPS_ADJ_RUN = 1'b1
  } sps_adj_state_t;

endpackage
`default_nettype wire

// ==== sps_step_scale.sv ====
`timescale 1ns/1ps
`default_nettype none
module sps_step_scale (
  // current step and keys
  input wire logic [sps_pkg::CUT_W-1:0] step_i,
  input wire logic grow_i,
  input wire logic shrink_i,
  // new step
  output logic [sps_pkg::CUT_W-1:0] step_o
);
  logic [2*sps_pkg::CUT_W-1:0] grown;

  always_comb begin
    grown = (2*sps_pkg::CUT_W)'(step_i) * (2*sps_pkg::CUT_W)'(sps_pkg::STEP_FACTOR);
    step_o = step_i;
    if (grow_i) begin
      // capped so the step can never exceed the cutoff range
      if (grown > (2*sps_pkg::CUT_W)'(sps_pkg::STEP_MAX)) begin
        step_o = sps_pkg::STEP_MAX;
      end else begin
        step_o = sps_pkg::CUT_W'(grown);
      end
    end else if (shrink_i) begin
      if (step_i < sps_pkg::STEP_FACTOR) begin
        step_o = sps_pkg::STEP_RESET;
      end else begin
        step_o = step_i / sps_pkg::STEP_FACTOR;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sps_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sps_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sensor count pulses, physical direction
  input wire logic sens_cw_i,
  input wire logic sens_ccw_i,
  // commanded motion, scale direction
  input wire logic cmd_plus_i,
  input wire logic cmd_minus_i,
  // hardware over-travel inputs
  input wire logic plus_limit_input_i,
  input wire logic minus_limit_input_i,
  // motor drive, physical direction
  output logic drive_cw_o,
  output logic drive_ccw_o,
  // position feedback quadrature
  output logic fb_a_o,
  output logic fb_b_o,
  // filter cutoffs in use
  output logic [sps_pkg::CUT_W-1:0] primary_lowpass_cutoff_o,
  output logic [sps_pkg::CUT_W-1:0] secondary_lowpass_cutoff_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] sps_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic sps_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr == ofs;
  endfunction

  // ----------------------------------------------------------------
  // bus strobes
  // ----------------------------------------------------------------
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic req;
  logic wr;
  logic [31:0] wval;

  // one strobe per request: the access acts in the cycle ack is raised
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr = req && wb_we_i;

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic flip_reg, flip_next;
  logic unlocked_reg, unlocked_next;
  logic refused_reg, refused_next;
  logic [sps_pkg::POS_W-1:0] soft_plus_reg, soft_plus_next;
  logic [sps_pkg::POS_W-1:0] soft_minus_reg, soft_minus_next;
  logic [sps_pkg::CUT_W-1:0] pri_reg, pri_next;
  logic [sps_pkg::CUT_W-1:0] sec_reg, sec_next;
  logic [31:0] soft_plus_w, soft_minus_w;
  logic [7:0] keys;

  assign soft_plus_w = sps_merge(32'(soft_plus_reg), wb_dat_i, wb_sel_i);
  assign soft_minus_w = sps_merge(32'(soft_minus_reg), wb_dat_i, wb_sel_i);
  assign wval = sps_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
  assign keys = (wr && sps_hit(wb_adr_i, sps_pkg::OFS_ADJ_KEY)) ? wval[7:0] : 8'h00;

  // ----------------------------------------------------------------
  // adjustment state
  // ----------------------------------------------------------------
  sps_pkg::sps_adj_state_t adj_reg, adj_next;
  logic adj_sec_reg, adj_sec_next;
  logic first_reg, first_next;
  logic [sps_pkg::CUT_W-1:0] work_reg, work_next;
  logic [sps_pkg::CUT_W-1:0] orig_reg, orig_next;
  logic [sps_pkg::CUT_W-1:0] step_reg, step_next;
  logic [sps_pkg::CUT_W-1:0] step_scaled;
  logic [sps_pkg::CUT_W:0] work_sum;

  sps_step_scale u_step (
    .step_i(step_reg),
    .grow_i(keys[sps_pkg::KEY_SHIFT_PLUS]),
    .shrink_i(keys[sps_pkg::KEY_STEP_REDUCE]),
    .step_o(step_scaled)
  );

  assign work_sum = {1'b0, work_reg} + {1'b0, step_reg};

  always_comb begin
    flip_next = flip_reg;
    unlocked_next = unlocked_reg;
    refused_next = refused_reg;
    soft_plus_next = soft_plus_reg;
    soft_minus_next = soft_minus_reg;
    pri_next = pri_reg;
    sec_next = sec_reg;
    adj_next = adj_reg;
    adj_sec_next = adj_sec_reg;
    first_next = first_reg;
    work_next = work_reg;
    orig_next = orig_reg;
    step_next = step_reg;
    if (wr) begin
      unique case (wb_adr_i)
        sps_pkg::OFS_UNLOCK: begin
          unlocked_next = (wval == sps_pkg::UNLOCK_KEY);
        end
        sps_pkg::OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            if (unlocked_reg) begin
              flip_next = wb_dat_i[sps_pkg::CTRL_FLIP_BIT];
              unlocked_next = 1'b0;
            end else begin
              refused_next = 1'b1;
            end
          end
        end
        sps_pkg::OFS_STATUS: begin
          if (wval[sps_pkg::ST_REFUSED_BIT]) begin
            refused_next = 1'b0;
          end
        end
        sps_pkg::OFS_SOFT_PLUS: begin
          if (soft_plus_w <= 32'(sps_pkg::POS_MAX)) begin
            soft_plus_next = sps_pkg::POS_W'(soft_plus_w);
          end else begin
            refused_next = 1'b1;
          end
        end
        sps_pkg::OFS_SOFT_MINUS: begin
          if (soft_minus_w <= 32'(sps_pkg::POS_MAX)) begin
            soft_minus_next = sps_pkg::POS_W'(soft_minus_w);
          end else begin
            refused_next = 1'b1;
          end
        end
        sps_pkg::OFS_PRI_LP: begin
          // direct writes are ignored while either adjustment, primary or secondary, is running
          if (adj_reg == sps_pkg::SPS_ADJ_IDLE) begin
            pri_next = sps_pkg::CUT_W'(sps_merge(32'(pri_reg), wb_dat_i, wb_sel_i));
          end
        end
        sps_pkg::OFS_SEC_LP: begin
          if (adj_reg == sps_pkg::SPS_ADJ_IDLE) begin
            sec_next = sps_pkg::CUT_W'(sps_merge(32'(sec_reg), wb_dat_i, wb_sel_i));
          end
        end
        default: begin
        end
      endcase
    end
    unique case (adj_reg)
      sps_pkg::SPS_ADJ_IDLE: begin
        if (keys[sps_pkg::KEY_START_PRI] || keys[sps_pkg::KEY_START_SEC]) begin
          adj_next = sps_pkg::SPS_ADJ_RUN;
          adj_sec_next = !keys[sps_pkg::KEY_START_PRI];
          first_next = 1'b1;
          step_next = sps_pkg::STEP_RESET;
          work_next = keys[sps_pkg::KEY_START_PRI] ? pri_reg : sec_reg;
          orig_next = keys[sps_pkg::KEY_START_PRI] ? pri_reg : sec_reg;
        end
      end
      sps_pkg::SPS_ADJ_RUN: begin
        step_next = step_scaled;
        if (keys[sps_pkg::KEY_ENTER]) begin
          adj_next = sps_pkg::SPS_ADJ_IDLE;
          if (adj_sec_reg) begin
            sec_next = work_reg;
          end else begin
            pri_next = work_reg;
          end
        end else if (keys[sps_pkg::KEY_BACKSPACE]) begin
          adj_next = sps_pkg::SPS_ADJ_IDLE;
          work_next = orig_reg;
        end else if (keys[sps_pkg::KEY_PLUS]) begin
          first_next = 1'b0;
          if (first_reg && !adj_sec_reg) begin
            work_next = sps_pkg::FIRST_PLUS_HZ;
          end else if (work_sum[sps_pkg::CUT_W]) begin
            work_next = sps_pkg::CUT_MAX;
          end else begin
            work_next = work_sum[sps_pkg::CUT_W-1:0];
          end
        end else if (keys[sps_pkg::KEY_MINUS]) begin
          first_next = 1'b0;
          // floor at STEP_RESET keeps the cutoff above zero hertz
          work_next = (work_reg > step_reg) ? work_reg - step_reg : sps_pkg::STEP_RESET;
        end
      end
    endcase
    // a new event outranks a software clear in the same cycle
    if (wr && sps_hit(wb_adr_i, sps_pkg::OFS_CTRL) && wb_sel_i[0] && !unlocked_reg) begin
      refused_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flip_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      refused_reg <= 1'b0;
      soft_plus_reg <= sps_pkg::POS_ZERO;
      soft_minus_reg <= sps_pkg::POS_ZERO;
      pri_reg <= sps_pkg::CUT_RESET_HZ;
      sec_reg <= sps_pkg::CUT_RESET_HZ;
      adj_reg <= sps_pkg::SPS_ADJ_IDLE;
      adj_sec_reg <= 1'b0;
      first_reg <= 1'b0;
      work_reg <= sps_pkg::CUT_RESET_HZ;
      orig_reg <= sps_pkg::CUT_RESET_HZ;
      step_reg <= sps_pkg::STEP_RESET;
    end else begin
      flip_reg <= flip_next;
      unlocked_reg <= unlocked_next;
      refused_reg <= refused_next;
      soft_plus_reg <= soft_plus_next;
      soft_minus_reg <= soft_minus_next;
      pri_reg <= pri_next;
      sec_reg <= sec_next;
      adj_reg <= adj_next;
      adj_sec_reg <= adj_sec_next;
      first_reg <= first_next;
      work_reg <= work_next;
      orig_reg <= orig_next;
      step_reg <= step_next;
    end
  end

  // ----------------------------------------------------------------
  // position count and feedback
  // ----------------------------------------------------------------
  logic [sps_pkg::POS_W-1:0] pos_reg, pos_next;
  logic [1:0] quad_reg, quad_next;
  logic phys_cw, phys_ccw, cnt_up, cnt_dn;
  logic [sps_pkg::DEG_W-1:0] deg_val;

  assign phys_cw = sens_cw_i && !sens_ccw_i;
  assign phys_ccw = sens_ccw_i && !sens_cw_i;
  assign cnt_up = flip_reg ? phys_ccw : phys_cw;
  assign cnt_dn = flip_reg ? phys_cw : phys_ccw;

  always_comb begin
    pos_next = pos_reg;
    if (cnt_up) begin
      pos_next = (pos_reg == sps_pkg::POS_MAX) ? sps_pkg::POS_ZERO : pos_reg + 1'b1;
    end else if (cnt_dn) begin
      pos_next = (pos_reg == sps_pkg::POS_ZERO) ? sps_pkg::POS_MAX : pos_reg - 1'b1;
    end
    // gray sequence follows the shaft, never the scale sense
    quad_next = quad_reg;
    if (phys_cw) begin
      quad_next = {quad_reg[0], ~quad_reg[1]};
    end else if (phys_ccw) begin
      quad_next = {~quad_reg[0], quad_reg[1]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_reg <= sps_pkg::POS_ZERO;
      quad_reg <= 2'h0;
    end else begin
      pos_reg <= pos_next;
      quad_reg <= quad_next;
    end
  end

  sps_deg_conv u_deg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pos_i(pos_reg),
    .deg_o(deg_val)
  );

  // ----------------------------------------------------------------
  // motion gating
  // ----------------------------------------------------------------
  logic soft_en, soft_ot;
  logic want_cw, want_ccw, soft_blk_plus;
  logic cw_reg, cw_next, ccw_reg, ccw_next;

  // off-limits area runs upward from the plus limit to the minus limit
  assign soft_en = soft_plus_reg != soft_minus_reg;
  assign soft_ot = soft_en && ((soft_plus_reg < soft_minus_reg) ?
                   (pos_reg >= soft_plus_reg && pos_reg <= soft_minus_reg) :
                   (pos_reg >= soft_plus_reg || pos_reg <= soft_minus_reg));
  // inside the area only motion back out toward minus is allowed
  assign soft_blk_plus = soft_ot;

  always_comb begin
    want_cw = 1'b0;
    want_ccw = 1'b0;
    if (cmd_plus_i && !cmd_minus_i && !soft_blk_plus) begin
      want_cw = !flip_reg;
      want_ccw = flip_reg;
    end else if (cmd_minus_i && !cmd_plus_i) begin
      want_cw = flip_reg;
      want_ccw = !flip_reg;
    end
    cw_next = want_cw && !plus_limit_input_i;
    ccw_next = want_ccw && !minus_limit_input_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cw_reg <= 1'b0;
      ccw_reg <= 1'b0;
    end else begin
      cw_reg <= cw_next;
      ccw_reg <= ccw_next;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    ack_next = req;
    rdat_next = rdat_reg;
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        sps_pkg::OFS_CTRL: rdat_next = 32'(flip_reg);
        sps_pkg::OFS_STATUS: begin
          rdat_next = 32'h0000_0000;
          rdat_next[sps_pkg::ST_UNLOCKED_BIT] = unlocked_reg;
          rdat_next[sps_pkg::ST_REFUSED_BIT] = refused_reg;
          rdat_next[sps_pkg::ST_ADJ_BIT] = adj_reg == sps_pkg::SPS_ADJ_RUN;
          rdat_next[sps_pkg::ST_SOFT_OT_BIT] = soft_ot;
          rdat_next[sps_pkg::ST_ADJ_SEC_BIT] = adj_sec_reg;
        end
        sps_pkg::OFS_POS_COUNT: rdat_next = 32'(pos_reg);
        sps_pkg::OFS_POS_DEG: rdat_next = 32'(deg_val);
        sps_pkg::OFS_SOFT_PLUS: rdat_next = 32'(soft_plus_reg);
        sps_pkg::OFS_SOFT_MINUS: rdat_next = 32'(soft_minus_reg);
        sps_pkg::OFS_PRI_LP: rdat_next = 32'(pri_reg);
        sps_pkg::OFS_SEC_LP: rdat_next = 32'(sec_reg);
        sps_pkg::OFS_ADJ_STEP: rdat_next = 32'(step_reg);
        default: rdat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [sps_pkg::CUT_W-1:0] pri_out_reg, sec_out_reg;

  // the filters track the working value live while adjusting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_out_reg <= sps_pkg::CUT_RESET_HZ;
      sec_out_reg <= sps_pkg::CUT_RESET_HZ;
    end else begin
      pri_out_reg <= (adj_next == sps_pkg::SPS_ADJ_RUN && !adj_sec_next) ? work_next : pri_next;
      sec_out_reg <= (adj_next == sps_pkg::SPS_ADJ_RUN && adj_sec_next) ? work_next : sec_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign drive_cw_o = cw_reg;
  assign drive_ccw_o = ccw_reg;
  assign fb_a_o = quad_reg[1];
  assign fb_b_o = quad_reg[0];
  assign primary_lowpass_cutoff_o = pri_out_reg;
  assign secondary_lowpass_cutoff_o = sec_out_reg;

endmodule
`default_nettype wire

// ==== sps_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module sps_top_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic cmd_plus_i,
  input wire logic cmd_minus_i,
  input wire logic plus_limit_input_i,
  input wire logic minus_limit_input_i,
  input wire logic drive_cw_o,
  input wire logic drive_ccw_o,
  input wire logic fb_a_o,
  input wire logic fb_b_o,
  input wire logic [sps_pkg::CUT_W-1:0] primary_lowpass_cutoff_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_on_take_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h30
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  plus_block_a: assert property (plus_limit_input_i |=> !drive_cw_o)
    else $error("cw drive past plus limit");
  minus_block_a: assert property (minus_limit_input_i |=> !drive_ccw_o)
    else $error("ccw drive past minus limit");
  drive_idle_a: assert property (!cmd_plus_i && !cmd_minus_i |=> !drive_cw_o && !drive_ccw_o)
    else $error("drive without command");
  fb_gray_a: assert property (!($changed(fb_a_o) && $changed(fb_b_o)))
    else $error("feedback skipped a phase");
  reset_cutoff_a: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> primary_lowpass_cutoff_o == 16'h00C8) else $error("cutoff reset wrong");
  cov_wr_c: cover property (wb_ack_o && wb_we_i);
  cov_cw_c: cover property (drive_cw_o);
  cov_ccw_c: cover property (drive_ccw_o);
endmodule
bind sps_top sps_top_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .cmd_plus_i(cmd_plus_i), .cmd_minus_i(cmd_minus_i),
  .plus_limit_input_i(plus_limit_input_i), .minus_limit_input_i(minus_limit_input_i),
  .drive_cw_o(drive_cw_o), .drive_ccw_o(drive_ccw_o), .fb_a_o(fb_a_o), .fb_b_o(fb_b_o),
  .primary_lowpass_cutoff_o(primary_lowpass_cutoff_o));
`default_nettype wire

// ==== sps_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module sps_top_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, d;
  logic [3:0] sel = 4'h0;
  logic ack, scw, sccw, cplus = 1'b0, cminus = 1'b0, lplus = 1'b0, lminus = 1'b0;
  logic dcw, dccw, fa, fb, mcw = 1'b0, mccw = 1'b0, slow = 1'b0;
  logic [15:0] pri, sec;
  int n_fail = 0, n_compared = 0;
  always #10 clk_i = ~clk_i;
  sps_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sens_cw_i(scw), .sens_ccw_i(sccw), .cmd_plus_i(cplus), .cmd_minus_i(cminus),
    .plus_limit_input_i(lplus), .minus_limit_input_i(lminus), .drive_cw_o(dcw),
    .drive_ccw_o(dccw), .fb_a_o(fa), .fb_b_o(fb), .primary_lowpass_cutoff_o(pri),
    .secondary_lowpass_cutoff_o(sec));
  sps_motor_model mot_u (.clk_i(clk_i), .drive_cw_i(dcw), .drive_ccw_i(dccw), .man_cw_i(mcw),
    .man_ccw_i(mccw), .slow_i(slow), .sens_cw_o(scw), .sens_ccw_o(sccw));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // master holds the request until the edge that samples ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic key(input int b);
    wr(sps_pkg::OFS_ADJ_KEY, 32'h1 << b);
  endtask
  task automatic pulse(input logic cw);
    @(posedge clk_i);
    mcw <= cw;
    mccw <= !cw;
    @(posedge clk_i);
    mcw <= 1'b0;
    mccw <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic hold(input logic p, input logic m, input logic lp, input logic lm);
    @(posedge clk_i);
    cplus <= p;
    cminus <= m;
    lplus <= lp;
    lminus <= lm;
    repeat (4) @(posedge clk_i);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("pri reset", pri, 32'h00C8);
    rd(sps_pkg::OFS_POS_COUNT);
    check("pos reset", d, 32'h0);
    rd(8'h30);
    check("unmapped", d, 32'h0);
  endtask
  task automatic t_wrap();
    pulse(1'b0);
    rd(sps_pkg::OFS_POS_COUNT);
    check("pos wrap", d, 32'h0027_FFFF);
    check("fb ccw", {fa, fb}, 32'h2);
    rd(sps_pkg::OFS_POS_DEG);
    check("deg", d, 32'h0000_8C9F);
    pulse(1'b1);
    rd(sps_pkg::OFS_POS_COUNT);
    check("pos cw", d, 32'h0);
  endtask
  task automatic t_flip();
    wr(sps_pkg::OFS_CTRL, 32'h1);
    rd(sps_pkg::OFS_CTRL);
    check("flip locked", d, 32'h0);
    rd(sps_pkg::OFS_STATUS);
    check("refused", d & 32'h2, 32'h2);
    wr(sps_pkg::OFS_UNLOCK, sps_pkg::UNLOCK_KEY);
    wr(sps_pkg::OFS_CTRL, 32'h1);
    rd(sps_pkg::OFS_CTRL);
    check("flip set", d, 32'h1);
    pulse(1'b1);
    rd(sps_pkg::OFS_POS_COUNT);
    check("pos flip", d, 32'h0027_FFFF);
    check("fb flip cw", {fa, fb}, 32'h1);
    hold(1'b1, 1'b0, 1'b0, 1'b0);
    check("plus ccw", {dcw, dccw}, 32'h1);
    hold(1'b0, 1'b1, 1'b1, 1'b0);
    check("limit cw", {dcw, dccw}, 32'h0);
    hold(1'b0, 1'b1, 1'b0, 1'b0);
    check("minus cw", {dcw, dccw}, 32'h2);
    hold(1'b0, 1'b0, 1'b0, 1'b0);
    wr(sps_pkg::OFS_UNLOCK, sps_pkg::UNLOCK_KEY);
    wr(sps_pkg::OFS_CTRL, 32'h0);
  endtask
  task automatic t_motion();
    @(posedge clk_i);
    slow <= 1'b1;
    hold(1'b1, 1'b0, 1'b0, 1'b0);
    check("plus cw", {dcw, dccw}, 32'h2);
    hold(1'b0, 1'b1, 1'b0, 1'b1);
    check("limit ccw", {dcw, dccw}, 32'h0);
    hold(1'b0, 1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_soft();
    wr(sps_pkg::OFS_STATUS, 32'h2);
    wr(sps_pkg::OFS_SOFT_PLUS, 32'h0028_0000);
    rd(sps_pkg::OFS_STATUS);
    check("soft refused", d & 32'h2, 32'h2);
    rd(sps_pkg::OFS_SOFT_PLUS);
    check("soft kept", d, 32'h0);
    // area from 0 up to the last count covers the whole turn
    wr(sps_pkg::OFS_SOFT_MINUS, 32'h0027_FFFF);
    rd(sps_pkg::OFS_SOFT_MINUS);
    check("soft minus", d, 32'h0027_FFFF);
    rd(sps_pkg::OFS_STATUS);
    check("soft area", d & 32'h8, 32'h8);
    hold(1'b1, 1'b0, 1'b0, 1'b0);
    check("soft blocks plus", {dcw, dccw}, 32'h0);
    hold(1'b0, 1'b1, 1'b0, 1'b0);
    check("soft lets minus", {dcw, dccw}, 32'h1);
    hold(1'b0, 1'b0, 1'b0, 1'b0);
    wr(sps_pkg::OFS_SOFT_MINUS, 32'h0);
  endtask
  task automatic t_adj();
    key(sps_pkg::KEY_START_PRI);
    key(sps_pkg::KEY_PLUS);
    check("first plus", pri, 32'h03E8);
    key(sps_pkg::KEY_SHIFT_PLUS);
    rd(sps_pkg::OFS_ADJ_STEP);
    check("step x10", d, 32'hA);
    key(sps_pkg::KEY_PLUS);
    check("plus 10", pri, 32'h03F2);
    key(sps_pkg::KEY_STEP_REDUCE);
    key(sps_pkg::KEY_MINUS);
    check("minus 1", pri, 32'h03F1);
    key(sps_pkg::KEY_BACKSPACE);
    check("restore", pri, 32'h00C8);
    key(sps_pkg::KEY_START_PRI);
    key(sps_pkg::KEY_PLUS);
    key(sps_pkg::KEY_ENTER);
    rd(sps_pkg::OFS_PRI_LP);
    check("commit", d, 32'h03E8);
    key(sps_pkg::KEY_START_SEC);
    key(sps_pkg::KEY_PLUS);
    key(sps_pkg::KEY_ENTER);
    check("sec plus", sec, 32'h00C9);
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    t_reset();
    t_wrap();
    t_flip();
    t_motion();
    t_soft();
    t_adj();
    finish_test();
  end
endmodule
`default_nettype wire
